// ### inc/amcs_pkg.sv
package amcs_pkg;

  // Clock rates and the internal conversion clock
  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned CLK_NS       = 8;
  localparam int unsigned ICLK_HZ      = 4_500_000;
  localparam int unsigned ICLK_DIV     = CLK_HZ / ICLK_HZ;
  localparam logic [4:0]  ICLK_DIV_M1  = 5'(ICLK_DIV - 1);

  // Internal clock start, least delay after the 8th falling edge
  localparam int unsigned ICLK_START_NS = 100;
  localparam int unsigned START_CYC     = (ICLK_START_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [5:0]  START_CYC_M1  = 6'(START_CYC - 1);

  // Internal clock counts
  localparam int unsigned ACQ_ICLK  = 11;
  localparam int unsigned CONV_ICLK = 16;
  localparam logic [4:0]  ACQ_M1    = 5'(ACQ_ICLK - 1);
  localparam logic [4:0]  CONV_M1   = 5'(CONV_ICLK - 1);

  // Result and serial word layout, counted in serial clocks
  localparam int unsigned RES_W         = 14;
  localparam logic [3:0]  RES_MSB       = 4'hD;
  localparam logic [3:0]  RD_MAX        = 4'hF;
  localparam logic [4:0]  BYTE_BITS     = 5'h08;
  localparam logic [4:0]  BYTE_LAST     = 5'h07;
  localparam logic [4:0]  EXT_CLK_SAMP  = 5'h0E;
  localparam logic [4:0]  EXT_ACQ_SAMP  = 5'h10;
  localparam logic [4:0]  EXT_CLK_B13   = 5'h10;
  localparam logic [4:0]  EXT_CLK_LAST  = 5'h1D;
  localparam logic [4:0]  EXT_CLK_LEN   = 5'h1C;
  localparam logic [4:0]  EXT_ACQ_LEN   = 5'h10;
  localparam logic [4:0]  W_CNT_MAX     = 5'h1F;

  // Low nibble tags of the first byte
  localparam logic [3:0]  MODE_TAG = 4'h8;
  localparam logic [3:0]  CONV_TAG = 4'h0;

  // Event bits crossing into the core domain
  localparam int unsigned EV_BYTE  = 0;
  localparam int unsigned EV_CONV  = 1;
  localparam int unsigned EV_START = 2;
  localparam int unsigned EV_SAMP  = 3;

  typedef enum logic [2:0] {
    M_EXT = 3'h0, M_ACQ = 3'h1, M_INT  = 3'h2, M_RSV3 = 3'h3,
    M_RESET = 3'h4, M_RSV5 = 3'h5, M_PART = 3'h6, M_FULL = 3'h7
  } amcs_mode_e;

  typedef enum logic [1:0] {
    P_ON = 2'h0, P_PART = 2'h1, P_FULL = 2'h3
  } amcs_pwr_e;

  typedef enum logic [1:0] {
    S_IDLE = 2'h0, S_DLY = 2'h1, S_ACQ = 2'h3, S_CONV = 2'h2
  } amcs_state_e;

  typedef struct packed {
    logic       start;
    logic       op_mode_bit_hi;
    logic       op_mode_bit_mid;
    logic       op_mode_bit_lo;
    logic [3:0] tag;
  } amcs_ctl_byte_s;

endpackage : amcs_pkg

// ### verilog/amcs_sequencer.sv
`timescale 1ns/1ps

module amcs_sequencer (
  // Core clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  // Serial link
  input  wire logic                 sclk,
  input  wire logic                 cs_n,
  input  wire logic                 din,
  output logic                      dout_o,
  output logic                      dout_oe_n,
  output logic                      conversion_done_strobe,
  // Converter core
  input  wire logic [13:0]          analog_code,
  output amcs_pkg::amcs_mode_e      op_mode,
  output amcs_pkg::amcs_pwr_e       pwr_state,
  output logic                      cfg_defaults
);

  localparam int DLY_N = amcs_pkg::START_CYC;

  amcs_pkg::amcs_ctl_byte_s byte_r;
  amcs_pkg::amcs_mode_e     op_mode_r;
  amcs_pkg::amcs_mode_e     code;
  amcs_pkg::amcs_mode_e     m_s1_r;
  amcs_pkg::amcs_mode_e     m_s2_r;
  amcs_pkg::amcs_pwr_e      pwr_r;
  amcs_pkg::amcs_state_e    st_r;
  logic                     word_act_r;
  logic                     conv_word_r;
  logic [4:0]               w_cnt_r;
  logic [6:0]               sh_r;
  logic [7:0]               nb;
  logic [4:0]               wlen;
  logic                     start_hit;
  logic                     byte_end;
  logic                     byte_tgl_r;
  logic                     start_tgl_r;
  logic                     conv_tgl_r;
  logic                     samp_tgl_r;
  logic [3:0]               rd_cnt_r;
  logic [3:0]               rd_idx;
  logic [4:0]               ext_idx;
  logic                     dout_r;
  logic [3:0]               sy1_r;
  logic [3:0]               sy2_r;
  logic [3:0]               sy3_r;
  logic [3:0]               evt;
  logic                     defaults_r;
  logic                     strobe_r;
  logic [13:0]              res_r;
  logic [5:0]               dly_r;
  logic [4:0]               div_r;
  logic [4:0]               ic_r;
  logic                     iclk_fall;
  logic                     conv_done;
  logic                     in_dly;

  //////////////////////////////////////////////////////////////////////////////
  // Link domain, rising edge: word capture

  assign nb = {sh_r, din};

  always_comb begin
    if (!conv_word_r) begin
      wlen = amcs_pkg::BYTE_BITS;
    end else if (m_s2_r == amcs_pkg::M_EXT) begin
      wlen = amcs_pkg::EXT_CLK_LEN;
    end else if (m_s2_r == amcs_pkg::M_ACQ) begin
      wlen = amcs_pkg::EXT_ACQ_LEN;
    end else begin
      wlen = amcs_pkg::BYTE_BITS;
    end
  end

  // A new word may start only once the previous one has run its length
  assign start_hit = !cs_n && din && (!word_act_r || w_cnt_r >= wlen);
  assign byte_end  = !cs_n && word_act_r && (w_cnt_r == amcs_pkg::BYTE_LAST);

  // Deselect clears the frame, since the link clock may stop with it
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      word_act_r  <= 1'b0;
      w_cnt_r     <= 5'h00;
      sh_r        <= 7'h00;
      conv_word_r <= 1'b0;
    end else if (start_hit) begin
      word_act_r  <= 1'b1;
      w_cnt_r     <= 5'h01;
      sh_r        <= 7'h01;
      conv_word_r <= 1'b0;
    end else if (word_act_r) begin
      if (w_cnt_r != amcs_pkg::W_CNT_MAX) begin
        w_cnt_r <= w_cnt_r + 5'h01;
      end
      sh_r <= nb[6:0];
      if (byte_end) begin
        conv_word_r <= (nb[3:0] == amcs_pkg::CONV_TAG);
      end
    end
  end

  // Byte data stays put for at least eight link clocks, so the core reads it
  // after the toggle has crossed without a handshake back
  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      byte_r      <= '0;
      byte_tgl_r  <= 1'b0;
      start_tgl_r <= 1'b0;
    end else begin
      if (start_hit) begin
        start_tgl_r <= ~start_tgl_r;
      end
      if (byte_end && nb[3:0] == amcs_pkg::MODE_TAG) begin
        byte_r     <= amcs_pkg::amcs_ctl_byte_s'(nb);
        byte_tgl_r <= ~byte_tgl_r;
      end
    end
  end

  // Mode copy for word length; it only changes between words
  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      m_s1_r <= amcs_pkg::M_EXT;
      m_s2_r <= amcs_pkg::M_EXT;
    end else begin
      m_s1_r <= op_mode_r;
      m_s2_r <= m_s1_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link domain, falling edge: sample instants and data out

  always_ff @(negedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      samp_tgl_r <= 1'b0;
      conv_tgl_r <= 1'b0;
    end else if (!cs_n && conv_word_r) begin
      if ((m_s2_r == amcs_pkg::M_EXT && w_cnt_r == amcs_pkg::EXT_CLK_SAMP) ||
          (m_s2_r == amcs_pkg::M_ACQ && w_cnt_r == amcs_pkg::EXT_ACQ_SAMP)) begin
        samp_tgl_r <= ~samp_tgl_r;
      end
      if (m_s2_r == amcs_pkg::M_INT && w_cnt_r == amcs_pkg::BYTE_BITS) begin
        conv_tgl_r <= ~conv_tgl_r;
      end
    end
  end

  assign ext_idx = amcs_pkg::EXT_CLK_LAST - w_cnt_r;
  assign rd_idx  = amcs_pkg::RES_MSB - rd_cnt_r;

  // Result is held steady by the core while it is shifted out
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      rd_cnt_r <= 4'h0;
      dout_r   <= 1'b0;
    end else if (conv_word_r && m_s2_r == amcs_pkg::M_EXT &&
                 w_cnt_r >= amcs_pkg::EXT_CLK_B13 && w_cnt_r <= amcs_pkg::EXT_CLK_LAST) begin
      dout_r <= res_r[ext_idx[3:0]];
    end else if (!word_act_r) begin
      dout_r <= (rd_cnt_r <= amcs_pkg::RES_MSB) ? res_r[rd_idx] : 1'b0;
      if (rd_cnt_r != amcs_pkg::RD_MAX) begin
        rd_cnt_r <= rd_cnt_r + 4'h1;
      end
    end else begin
      dout_r <= 1'b0;
    end
  end

  assign dout_o    = dout_r;
  assign dout_oe_n = cs_n;

  //////////////////////////////////////////////////////////////////////////////
  // Core domain: event crossing

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sy1_r <= 4'h0;
      sy2_r <= 4'h0;
      sy3_r <= 4'h0;
    end else begin
      sy1_r <= {samp_tgl_r, start_tgl_r, conv_tgl_r, byte_tgl_r};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
    end
  end

  assign evt = sy2_r ^ sy3_r;

  //////////////////////////////////////////////////////////////////////////////
  // Core domain: mode and power

  assign code = amcs_pkg::amcs_mode_e'({byte_r.op_mode_bit_hi, byte_r.op_mode_bit_mid,
                                         byte_r.op_mode_bit_lo});

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      op_mode_r  <= amcs_pkg::M_EXT;
      pwr_r      <= amcs_pkg::P_ON;
      defaults_r <= 1'b0;
    end else begin
      defaults_r <= 1'b0;
      if (evt[amcs_pkg::EV_BYTE]) begin
        case (code)
          amcs_pkg::M_EXT, amcs_pkg::M_ACQ, amcs_pkg::M_INT: begin
            op_mode_r <= code;
            pwr_r     <= amcs_pkg::P_ON;
          end
          amcs_pkg::M_RESET: begin
            op_mode_r  <= amcs_pkg::M_EXT;
            pwr_r      <= amcs_pkg::P_ON;
            defaults_r <= 1'b1;
          end
          amcs_pkg::M_PART: pwr_r <= amcs_pkg::P_PART;
          amcs_pkg::M_FULL: pwr_r <= amcs_pkg::P_FULL;
          default: ;
        endcase
      end
    end
  end

  assign op_mode      = op_mode_r;
  assign pwr_state    = pwr_r;
  assign cfg_defaults = defaults_r;

  //////////////////////////////////////////////////////////////////////////////
  // Core domain: internal clock and conversion sequence

  assign iclk_fall = (div_r == amcs_pkg::ICLK_DIV_M1);
  assign conv_done = (st_r == amcs_pkg::S_CONV) && iclk_fall && (ic_r == amcs_pkg::CONV_M1);
  assign in_dly    = (st_r == amcs_pkg::S_DLY);

  always_ff @(posedge core_clk) begin
    if (sys_rst || st_r == amcs_pkg::S_IDLE || in_dly || iclk_fall) begin
      div_r <= 5'h00;
    end else begin
      div_r <= div_r + 5'h01;
    end
  end

  // Power-down aborts a conversion in flight
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r  <= amcs_pkg::S_IDLE;
      dly_r <= 6'h00;
      ic_r  <= 5'h00;
      res_r <= 14'h0000;
    end else if (pwr_r != amcs_pkg::P_ON) begin
      st_r <= amcs_pkg::S_IDLE;
    end else begin
      case (st_r)
        amcs_pkg::S_IDLE: begin
          if (evt[amcs_pkg::EV_SAMP] && op_mode_r == amcs_pkg::M_ACQ) begin
            res_r <= analog_code;
            ic_r  <= 5'h00;
            st_r  <= amcs_pkg::S_CONV;
          end else if (evt[amcs_pkg::EV_SAMP] && op_mode_r == amcs_pkg::M_EXT) begin
            res_r <= analog_code;
          end else if (evt[amcs_pkg::EV_CONV] && op_mode_r == amcs_pkg::M_INT) begin
            dly_r <= amcs_pkg::START_CYC_M1;
            st_r  <= amcs_pkg::S_DLY;
          end
        end
        amcs_pkg::S_DLY: begin
          if (dly_r == 6'h00) begin
            ic_r <= 5'h00;
            st_r <= amcs_pkg::S_ACQ;
          end else begin
            dly_r <= dly_r - 6'h01;
          end
        end
        amcs_pkg::S_ACQ: begin
          if (iclk_fall && ic_r == amcs_pkg::ACQ_M1) begin
            res_r <= analog_code;
            ic_r  <= 5'h00;
            st_r  <= amcs_pkg::S_CONV;
          end else if (iclk_fall) begin
            ic_r <= ic_r + 5'h01;
          end
        end
        amcs_pkg::S_CONV: begin
          if (conv_done) begin
            st_r <= amcs_pkg::S_IDLE;
          end else if (iclk_fall) begin
            ic_r <= ic_r + 5'h01;
          end
        end
        default: st_r <= amcs_pkg::S_IDLE;
      endcase
    end
  end

  // Completion wins over a start bit seen in the same cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      strobe_r <= 1'b0;
    end else if (conv_done && op_mode_r != amcs_pkg::M_EXT) begin
      strobe_r <= 1'b1;
    end else if (evt[amcs_pkg::EV_START] || op_mode_r == amcs_pkg::M_EXT) begin
      strobe_r <= 1'b0;
    end
  end

  assign conversion_done_strobe = strobe_r;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_ext_low;
    op_mode_r == amcs_pkg::M_EXT |=> !conversion_done_strobe;
  endproperty
  a_ext_low: assert property (p_ext_low) else $error("strobe high in mode 0");

  property p_rsv;
    evt[amcs_pkg::EV_BYTE] && (code == amcs_pkg::M_RSV3 || code == amcs_pkg::M_RSV5)
      |=> $stable(op_mode_r) && $stable(pwr_r);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved code changed mode");

  property p_reset;
    evt[amcs_pkg::EV_BYTE] && code == amcs_pkg::M_RESET
      |=> op_mode_r == amcs_pkg::M_EXT && pwr_r == amcs_pkg::P_ON && cfg_defaults ##1 !cfg_defaults;
  endproperty
  a_reset: assert property (p_reset) else $error("reset code failed");

  property p_part;
    evt[amcs_pkg::EV_BYTE] && code == amcs_pkg::M_PART |=> pwr_r == amcs_pkg::P_PART;
  endproperty
  a_part: assert property (p_part) else $error("partial power-down missed");

  property p_full;
    evt[amcs_pkg::EV_BYTE] && code == amcs_pkg::M_FULL |=> pwr_r == amcs_pkg::P_FULL;
  endproperty
  a_full: assert property (p_full) else $error("full power-down missed");

  property p_method;
    evt[amcs_pkg::EV_BYTE] && code inside {amcs_pkg::M_EXT, amcs_pkg::M_ACQ, amcs_pkg::M_INT}
      |=> pwr_r == amcs_pkg::P_ON && op_mode_r == $past(code);
  endproperty
  a_method: assert property (p_method) else $error("method byte not applied");

  property p_start_dly;
    $rose(st_r == amcs_pkg::S_ACQ) |-> $past(in_dly) && $past(in_dly, DLY_N);
  endproperty
  a_start_dly: assert property (p_start_dly) else $error("internal clock start early");

  // Upper bound leaves room for the three core cycles spent crossing
  property p_start_late;
    evt[amcs_pkg::EV_CONV] && op_mode_r == amcs_pkg::M_INT && st_r == amcs_pkg::S_IDLE &&
      pwr_r == amcs_pkg::P_ON |-> ##[1:46] st_r == amcs_pkg::S_ACQ;
  endproperty
  a_start_late: assert property (p_start_late) else $error("internal clock start late");

  property p_acq_samp;
    st_r == amcs_pkg::S_ACQ && iclk_fall && ic_r == amcs_pkg::ACQ_M1
      |=> st_r == amcs_pkg::S_CONV && res_r == $past(analog_code);
  endproperty
  a_acq_samp: assert property (p_acq_samp) else $error("mode 2 sample missed");

  property p_done;
    conv_done && op_mode_r != amcs_pkg::M_EXT |=> conversion_done_strobe [*2];
  endproperty
  a_done: assert property (p_done) else $error("strobe not raised");

  property p_clear;
    evt[amcs_pkg::EV_START] && !conv_done |=> !conversion_done_strobe;
  endproperty
  a_clear: assert property (p_clear) else $error("strobe not cleared");

  property p_mode1;
    evt[amcs_pkg::EV_SAMP] && op_mode_r == amcs_pkg::M_ACQ && st_r == amcs_pkg::S_IDLE &&
      pwr_r == amcs_pkg::P_ON |=> st_r == amcs_pkg::S_CONV ##1 st_r == amcs_pkg::S_CONV;
  endproperty
  a_mode1: assert property (p_mode1) else $error("mode 1 conversion not started");

endmodule : amcs_sequencer

// ### testbench/amcs_host_model.sv
`timescale 1ns/1ps
module amcs_host_model (
  // Serial link toward the device
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout_o,
  input  wire logic dout_oe_n
);
  // 80 ns serial period; the clock stands still low between frames except during noise
  localparam time HALF = 40;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One frame: first byte, then zeros; dout is sampled at every rising edge
  task automatic frame(input logic [7:0] first, input int n, output logic [31:0] rx);
    rx   = '0;
    cs_n = 1'b0;
    #HALF;
    for (int i = 0; i < n; i++) begin
      din = (i < 8) ? first[7 - i] : 1'b0;
      #HALF;
      sclk = 1'b1;
      // A released line has no pull, so it shows the inverse and never matches
      rx   = {rx[30:0], dout_oe_n ? ~dout_o : dout_o};
      #HALF;
      sclk = 1'b0;
    end
    #HALF;
    cs_n = 1'b1;
    din  = 1'b0;
  endtask : frame

  ////////////////////////////////////////////////////////////////////////////////
  // Deliberate activity while deselected, shaped like a power-down byte
  task automatic noise(input int n);
    for (int i = 0; i < n; i++) begin
      din = ((i % 8) < 5);
      #HALF;
      sclk = 1'b1;
      #HALF;
      sclk = 1'b0;
    end
    din = 1'b0;
  endtask : noise
endmodule : amcs_host_model

// ### testbench/adc_mode_control_sequencer_tb_top.sv
`timescale 1ns/1ps
module adc_mode_control_sequencer_tb_top;
  logic                 core_clk;
  logic                 sys_rst;
  logic                 sclk;
  logic                 cs_n;
  logic                 din;
  logic                 dout_o;
  logic                 dout_oe_n;
  logic                 strobe;
  logic                 cfg_defaults;
  logic [13:0]          analog_code;
  amcs_pkg::amcs_mode_e op_mode;
  amcs_pkg::amcs_pwr_e  pwr_state;
  int                   n_errors;
  int                   check_count;
  int                   cyc;
  int                   cfg_seen;
  int                   cfg_exp;
  int                   mode_m;
  int                   pwr_m;
  logic [31:0]          seed;
  logic [31:0]          rx;

  amcs_sequencer dut (
    .core_clk               (core_clk),
    .sys_rst                (sys_rst),
    .sclk                   (sclk),
    .cs_n                   (cs_n),
    .din                    (din),
    .dout_o                 (dout_o),
    .dout_oe_n              (dout_oe_n),
    .conversion_done_strobe (strobe),
    .analog_code            (analog_code),
    .op_mode                (op_mode),
    .pwr_state              (pwr_state),
    .cfg_defaults           (cfg_defaults)
  );

  amcs_host_model host (
    .sclk      (sclk),
    .cs_n      (cs_n),
    .din       (din),
    .dout_o    (dout_o),
    .dout_oe_n (dout_oe_n)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Run ceiling and defaults pulse counter
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      n_errors = n_errors + 1;
      results();
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst === 1'b0 && cfg_defaults === 1'b1) cfg_seen = cfg_seen + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count = check_count + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  // Reference model: method and power state follow each accepted mode byte
  task automatic mode_byte(input int code);
    host.frame({1'b1, 3'(code), 4'h8}, 8, rx);
    case (code)
      0, 1, 2: begin
        mode_m = code;
        pwr_m  = int'(amcs_pkg::P_ON);
      end
      4: begin
        mode_m  = 0;
        pwr_m   = int'(amcs_pkg::P_ON);
        cfg_exp = cfg_exp + 1;
      end
      6: pwr_m = int'(amcs_pkg::P_PART);
      7: pwr_m = int'(amcs_pkg::P_FULL);
      default: ;
    endcase
    repeat (10) @(posedge core_clk);
    #1;
    check(16'(op_mode), 16'(mode_m), "method");
    check(16'(pwr_state), 16'(pwr_m), "power");
    check(16'(strobe), 16'h0000, "strobe after start bit");
  endtask : mode_byte

  task automatic new_code();
    @(posedge core_clk);
    #1;
    analog_code = 14'(xs());
  endtask : new_code

  task automatic wait_strobe();
    for (int i = 0; i < 1500 && strobe !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    check(16'(strobe), 16'h0001, "strobe rise");
  endtask : wait_strobe

  // Internally converted methods: n serial clocks, then read two bytes
  task automatic int_conv(input int n);
    repeat (600) @(posedge core_clk);
    #1;
    check(16'(strobe), 16'h0000, "no start, no strobe");
    new_code();
    host.frame({1'b1, 3'(xs()), 4'h0}, n, rx);
    check(16'(strobe), 16'h0000, "strobe early");
    wait_strobe();
    host.frame(8'h00, 16, rx);
    check(16'(rx[14:1]), 16'(analog_code), "read back");
  endtask : int_conv

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed        = 32'h0000002D;
    sys_rst     = 1'b1;
    analog_code = '0;
    n_errors    = 0;
    check_count = 0;
    cyc         = 0;
    cfg_seen    = 0;
    cfg_exp     = 0;
    mode_m      = 0;
    pwr_m       = 0;
    repeat (3) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    check(16'(op_mode), 16'(amcs_pkg::M_EXT), "reset method");
    check(16'(pwr_state), 16'(amcs_pkg::P_ON), "reset power");
    // Odd offset keeps the serial clock out of step with the core clock
    #3;
    new_code();
    host.frame({1'b1, 3'(xs()), 4'h0}, 30, rx);
    check(16'(rx[13:0]), 16'(analog_code), "ext clock result");
    check(16'(strobe), 16'h0000, "strobe in ext clock");
    $display("test ext_clock done");
    mode_byte(1);
    int_conv(16);
    $display("test ext_acq done");
    mode_byte(2);
    int_conv(8);
    $display("test int_clock done");
    mode_byte(7);
    host.frame(8'h80, 8, rx);
    repeat (1000) @(posedge core_clk);
    #1;
    check(16'(strobe), 16'h0000, "start while powered down");
    // No conversion follows this exit, as the reference settling time is not waited
    mode_byte(2);
    $display("test power_down done");
    for (int c = 0; c < 8; c++) mode_byte(c);
    for (int k = 0; k < 16; k++) mode_byte(int'(xs() % 8));
    check(16'(cfg_seen), 16'(cfg_exp), "defaults pulses");
    $display("test mode_codes done");
    mode_byte(0);
    host.frame({1'b1, 3'h2, 4'h9}, 8, rx);
    repeat (10) @(posedge core_clk);
    check(16'(op_mode), 16'(amcs_pkg::M_EXT), "bad tag byte");
    host.noise(24);
    repeat (10) @(posedge core_clk);
    check(16'(pwr_state), 16'(amcs_pkg::P_ON), "deselected activity");
    check(16'(dout_oe_n), 16'h0001, "output floats");
    $display("test deselect done");
    results();
  end
endmodule : adc_mode_control_sequencer_tb_top
